// ---- hw/fps_pkg.sv ----
// =====================================================================
// Constants shared by the synthesizer control block
`default_nettype none
package fps_pkg;
  // =====================================================================
  // Register offsets (16-bit registers, word index)
  localparam logic [6:0] FPS_OFF_LOCK_STATUS = 7'h07;
  localparam logic [6:0] FPS_OFF_REF_DIV = 7'h19;
  localparam logic [6:0] FPS_OFF_MOD_ORDER = 7'h1b;
  localparam logic [6:0] FPS_OFF_FB_INT = 7'h1e;
  localparam logic [6:0] FPS_OFF_NUM_LO = 7'h1f;
  localparam logic [6:0] FPS_OFF_NUM_HI = 7'h20;
  localparam logic [6:0] FPS_OFF_DEN_LO = 7'h21;
  localparam logic [6:0] FPS_OFF_DEN_HI = 7'h22;
  localparam logic [6:0] FPS_OFF_SSC_EN = 7'h29;
  localparam logic [6:0] FPS_OFF_SSC_SEL = 7'h2a;
  localparam logic [6:0] FPS_OFF_LOCK_WIN = 7'h32;
  localparam logic [6:0] FPS_OFF_DET_CFG = 7'h33;
  // =====================================================================
  // Field positions
  localparam int FPS_BIT_LOCK_LIVE = 0;
  localparam int FPS_BIT_LOCK_STICKY = 1;
  localparam int FPS_BIT_SSC_EN = 15;
  localparam int FPS_BIT_SSC_TYPE = 5;
  localparam int FPS_POS_SSC_SEL = 1;
  localparam int FPS_POS_LOCK_WIN = 8;
  localparam int FPS_BIT_PFD_SE = 6;
  localparam int FPS_BIT_FRAC_CTRL = 10;
  // =====================================================================
  // Reset values
  localparam logic [7:0] FPS_RST_REF_DIV = 8'h01;
  localparam logic [1:0] FPS_RST_MOD_ORDER = 2'h0;
  localparam logic [14:0] FPS_RST_FB_INT = 15'h0060;
  localparam logic [15:0] FPS_RST_WORD = 16'h0000;
  localparam logic [7:0] FPS_RST_BYTE = 8'h00;
  localparam logic [2:0] FPS_RST_SSC_SEL = 3'h0;
  localparam logic [2:0] FPS_RST_LOCK_WIN = 3'h0;
  localparam logic FPS_RST_PFD_SE = 1'b1;
  // Denominator used when both denominator fields are zero
  localparam logic [24:0] FPS_DEN_FULL = 25'h1000000;
  // =====================================================================
  // Spread codes and timing
  localparam logic [2:0] FPS_SSC_LAST_CODE = 3'h3;
  localparam int FPS_CLK_HZ = 100000000;
  localparam int FPS_SSC_FMOD_HZ = 31500;
  localparam int FPS_SSC_HALF_INT = FPS_CLK_HZ / (2 * FPS_SSC_FMOD_HZ);
  localparam logic [10:0] FPS_SSC_HALF = FPS_SSC_HALF_INT[10:0];
  localparam logic [10:0] FPS_SSC_MID = FPS_SSC_HALF >> 1;
endpackage : fps_pkg
`default_nettype wire

// ---- hw/fps_tri.sv ----
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// Triangle ramp: climbs 0..HALF then falls back, one step per clock
module fps_tri
  import fps_pkg::*;
#(
  parameter logic [10:0] HALF = 11'h001
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  output logic [10:0] ramp
);
  logic [10:0] ramp_q;
  logic down_q;

  assign ramp = ramp_q;

  // Up/down counter, parked at zero while disabled
  always_ff @(posedge clk) begin
    if (rst || !en) begin
      ramp_q <= 11'h000;
      down_q <= 1'b0;
    end else if (!down_q) begin
      if (ramp_q == HALF - 11'h001) begin
        down_q <= 1'b1;
      end
      ramp_q <= ramp_q + 11'h001;
    end else begin
      if (ramp_q == 11'h001) begin
        down_q <= 1'b0;
      end
      ramp_q <= ramp_q - 11'h001;
    end
  end

  // R11 ramp stays bounded
  a_ramp_bound: assert property (@(posedge clk) disable iff (rst) ramp_q <= HALF) // R11
    else $error("ramp above half period");
  // R11 apex turns round
  a_ramp_apex: assert property (@(posedge clk) disable iff (rst) // R11
    (en && ramp_q == HALF && $past(en)) |=> (!en || ramp_q == HALF - 11'h001))
    else $error("ramp did not turn at apex");
endmodule : fps_tri
`default_nettype wire

// ---- hw/fps_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
//
// Contract
// R01 - PFD factor is reference divider value; zero selects doubler, factor one half.
// R02 - Oscillator equals PFD times integer divider plus fraction; integer is 15 bits.
// R03 - Numerator is upper 8-bit field joined above lower 16-bit field.
// R04 - Denominator joined likewise; all-zero denominator means two to the 24.
// R05 - Order zero is integer mode; 1, 2, 3 select shaper order.
// R06 - Software sets detector single-ended in integer, differential in fractional mode.
// R07 - Live lock shown in status and GPIO; sticky bit records lock loss.
// R08 - Software widens lock window to 7 for fractional mode with spread.
// R09 - Software keeps PFD frequency between 1 and 100 MHz.
// R10 - Software keeps oscillator between 2335 and 2615 MHz.
// R11 - Spread modulation is a triangle over time.
// R12 - Spread applies to synthesizer outputs only, never reference or PFD bypass.
// R13 - No spread while enable is 0; type selects down or center.
// R14 - Select codes 0..3 pick PFD and depth; codes 4..7 unused.
// R15 - Software uses spread only at 25 or 50 MHz PFD.
// R16 - Preset spread yields 31.5 kHz modulation rate.
// R17 - Loop acquires lock automatically after power-up when dividers are valid.
// R18 - Software keeps channel 2 powered in internal zero-delay mode.
// R19 - Sticky loss indication stays set until software clears it.
//
module fps_ctrl
  import fps_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic [6:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  output logic REG_RVALID,
  input wire logic LOCK_DETECT_IN,
  output logic LOCK_GPIO,
  output logic [7:0] REFERENCE_DIVIDE_VALUE,
  output logic PFD_DOUBLER_EN,
  output logic [14:0] FEEDBACK_INTEGER_VALUE,
  output logic [23:0] FRAC_NUM,
  output logic [24:0] FRAC_DEN,
  output logic [1:0] CASCADED_NOISE_SHAPER,
  output logic FRACTIONAL_MODE,
  output logic PFD_SINGLE_ENDED,
  output logic FRAC_PATH_CTRL,
  output logic [2:0] LOCK_WINDOW,
  output logic SSC_ACTIVE,
  output logic SSC_PFD_50M,
  output logic [15:0] SSC_OFFSET,
  output logic PLL_RUN
);
  // =====================================================================
  // Register storage
  logic [7:0] ref_div_q;
  logic [1:0] order_q;
  logic [14:0] fb_int_q;
  logic [15:0] num_lo_q;
  logic [7:0] num_hi_q;
  logic [15:0] den_lo_q;
  logic [7:0] den_hi_q;
  logic ssc_en_q;
  logic ssc_type_q;
  logic [2:0] ssc_sel_q;
  logic [2:0] lock_win_q;
  logic pfd_se_q;
  logic frac_ctrl_q;
  logic lock_live_q;
  logic lock_sticky_q;
  logic [15:0] rdata_d;
  logic sticky_clr;
  logic lock_lost;
  logic ssc_run;
  logic [10:0] ramp;
  logic [15:0] ramp_sh;

  // Software write of the register fields
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      ref_div_q <= FPS_RST_REF_DIV;
      order_q <= FPS_RST_MOD_ORDER;
      fb_int_q <= FPS_RST_FB_INT;
      num_lo_q <= FPS_RST_WORD;
      num_hi_q <= FPS_RST_BYTE;
      den_lo_q <= FPS_RST_WORD;
      den_hi_q <= FPS_RST_BYTE;
      ssc_en_q <= 1'b0;
      ssc_type_q <= 1'b0;
      ssc_sel_q <= FPS_RST_SSC_SEL;
      lock_win_q <= FPS_RST_LOCK_WIN;
      pfd_se_q <= FPS_RST_PFD_SE;
      frac_ctrl_q <= 1'b0;
    end else if (REG_WR) begin
      case (REG_ADDR)
        FPS_OFF_REF_DIV: ref_div_q <= REG_WDATA[7:0];
        FPS_OFF_MOD_ORDER: order_q <= REG_WDATA[1:0];
        FPS_OFF_FB_INT: fb_int_q <= REG_WDATA[14:0];
        FPS_OFF_NUM_LO: num_lo_q <= REG_WDATA;
        FPS_OFF_NUM_HI: num_hi_q <= REG_WDATA[7:0];
        FPS_OFF_DEN_LO: den_lo_q <= REG_WDATA;
        FPS_OFF_DEN_HI: den_hi_q <= REG_WDATA[7:0];
        FPS_OFF_SSC_EN: ssc_en_q <= REG_WDATA[FPS_BIT_SSC_EN];
        FPS_OFF_SSC_SEL: begin
          ssc_type_q <= REG_WDATA[FPS_BIT_SSC_TYPE];
          ssc_sel_q <= REG_WDATA[FPS_POS_SSC_SEL +: 3];
        end
        FPS_OFF_LOCK_WIN: lock_win_q <= REG_WDATA[FPS_POS_LOCK_WIN +: 3];
        FPS_OFF_DET_CFG: begin
          pfd_se_q <= REG_WDATA[FPS_BIT_PFD_SE];
          frac_ctrl_q <= REG_WDATA[FPS_BIT_FRAC_CTRL];
        end
        default: begin
        end
      endcase
    end
  end

  // =====================================================================
  // Register read port, one cycle latency, unmapped reads zero
  always_comb begin
    rdata_d = 16'h0000;
    case (REG_ADDR)
      FPS_OFF_LOCK_STATUS: begin
        rdata_d[FPS_BIT_LOCK_LIVE] = lock_live_q;
        rdata_d[FPS_BIT_LOCK_STICKY] = lock_sticky_q;
      end
      FPS_OFF_REF_DIV: rdata_d[7:0] = ref_div_q;
      FPS_OFF_MOD_ORDER: rdata_d[1:0] = order_q;
      FPS_OFF_FB_INT: rdata_d[14:0] = fb_int_q;
      FPS_OFF_NUM_LO: rdata_d = num_lo_q;
      FPS_OFF_NUM_HI: rdata_d[7:0] = num_hi_q;
      FPS_OFF_DEN_LO: rdata_d = den_lo_q;
      FPS_OFF_DEN_HI: rdata_d[7:0] = den_hi_q;
      FPS_OFF_SSC_EN: rdata_d[FPS_BIT_SSC_EN] = ssc_en_q;
      FPS_OFF_SSC_SEL: begin
        rdata_d[FPS_BIT_SSC_TYPE] = ssc_type_q;
        rdata_d[FPS_POS_SSC_SEL +: 3] = ssc_sel_q;
      end
      FPS_OFF_LOCK_WIN: rdata_d[FPS_POS_LOCK_WIN +: 3] = lock_win_q;
      FPS_OFF_DET_CFG: begin
        rdata_d[FPS_BIT_PFD_SE] = pfd_se_q;
        rdata_d[FPS_BIT_FRAC_CTRL] = frac_ctrl_q;
      end
      default: rdata_d = 16'h0000;
    endcase
  end

  // Read data and valid flops
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      REG_RDATA <= 16'h0000;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RDATA <= REG_RD ? rdata_d : 16'h0000;
      REG_RVALID <= REG_RD;
    end
  end

  // =====================================================================
  // Lock status
  assign lock_lost = lock_live_q && !LOCK_DETECT_IN;
  assign sticky_clr = REG_WR && (REG_ADDR == FPS_OFF_LOCK_STATUS) && REG_WDATA[FPS_BIT_LOCK_STICKY];

  // R07 live lock copies
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      lock_live_q <= 1'b0;
      LOCK_GPIO <= 1'b0;
    end else begin
      lock_live_q <= LOCK_DETECT_IN;
      LOCK_GPIO <= LOCK_DETECT_IN;
    end
  end

  // R19 sticky loss, set wins
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      lock_sticky_q <= 1'b0;
    end else if (lock_lost) begin
      lock_sticky_q <= 1'b1;
    end else if (sticky_clr) begin
      lock_sticky_q <= 1'b0;
    end
  end

  // =====================================================================
  // Divider and mode outputs
  // R01 R02 R03 R04 R05 divider image
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      REFERENCE_DIVIDE_VALUE <= FPS_RST_REF_DIV;
      PFD_DOUBLER_EN <= 1'b0;
      FEEDBACK_INTEGER_VALUE <= FPS_RST_FB_INT;
      FRAC_NUM <= 24'h000000;
      FRAC_DEN <= FPS_DEN_FULL;
      CASCADED_NOISE_SHAPER <= FPS_RST_MOD_ORDER;
      FRACTIONAL_MODE <= 1'b0;
      PFD_SINGLE_ENDED <= FPS_RST_PFD_SE;
      FRAC_PATH_CTRL <= 1'b0;
      LOCK_WINDOW <= FPS_RST_LOCK_WIN;
      PLL_RUN <= 1'b0;
    end else begin
      REFERENCE_DIVIDE_VALUE <= ref_div_q;
      PFD_DOUBLER_EN <= (ref_div_q == 8'h00);
      FEEDBACK_INTEGER_VALUE <= fb_int_q;
      FRAC_NUM <= {num_hi_q, num_lo_q};
      FRAC_DEN <= ({den_hi_q, den_lo_q} == 24'h000000) ? FPS_DEN_FULL : {1'b0, den_hi_q, den_lo_q};
      CASCADED_NOISE_SHAPER <= order_q;
      FRACTIONAL_MODE <= (order_q != 2'h0);
      PFD_SINGLE_ENDED <= pfd_se_q;
      FRAC_PATH_CTRL <= frac_ctrl_q;
      LOCK_WINDOW <= lock_win_q;
      // R17 acquisition starts at reset release
      PLL_RUN <= 1'b1;
    end
  end

  // =====================================================================
  // Spread modulation, only on synthesizer numerator path
  // R13 R14 spread gated by enable and valid code
  assign ssc_run = ssc_en_q && (ssc_sel_q <= FPS_SSC_LAST_CODE);

  // R16 triangle at modulation rate
  fps_tri #(
    .HALF(FPS_SSC_HALF)
  ) fps_tri_i (
    .clk(MCLK),
    .rst(RESET),
    .en(ssc_run),
    .ramp(ramp)
  );

  // Depth doubles for the 0.50 percent codes
  assign ramp_sh = ssc_sel_q[0] ? {4'h0, ramp, 1'b0} : {5'h00, ramp};

  // R11 R12 R13 offset down or centered
  always_ff @(posedge MCLK) begin
    if (RESET || !ssc_run) begin
      SSC_OFFSET <= 16'h0000;
      SSC_ACTIVE <= 1'b0;
      SSC_PFD_50M <= 1'b0;
    end else begin
      SSC_ACTIVE <= 1'b1;
      SSC_PFD_50M <= ssc_sel_q[1];
      if (ssc_type_q) begin
        SSC_OFFSET <= (ssc_sel_q[0] ? {4'h0, FPS_SSC_MID, 1'b0} : {5'h00, FPS_SSC_MID}) - ramp_sh;
      end else begin
        SSC_OFFSET <= 16'h0000 - ramp_sh;
      end
    end
  end

  // =====================================================================
  // Checks
  // R01 doubler on zero
  a_doubler_sel: assert property (@(posedge MCLK) disable iff (RESET) // R01
    (ref_div_q == 8'h00) |=> PFD_DOUBLER_EN)
    else $error("doubler not engaged for zero divider");
  // R02 integer field image
  a_int_field: assert property (@(posedge MCLK) disable iff (RESET) // R02
    ##1 FEEDBACK_INTEGER_VALUE == $past(fb_int_q))
    else $error("integer divider image wrong");
  // R03 numerator join
  a_num_join: assert property (@(posedge MCLK) disable iff (RESET) // R03
    ##1 FRAC_NUM == {$past(num_hi_q), $past(num_lo_q)})
    else $error("numerator join wrong");
  // R04 zero denominator full
  a_den_zero: assert property (@(posedge MCLK) disable iff (RESET) // R04
    (den_hi_q == 8'h00 && den_lo_q == 16'h0000) |=> FRAC_DEN == FPS_DEN_FULL)
    else $error("zero denominator not full scale");
  // R05 order sets mode
  a_order_mode: assert property (@(posedge MCLK) disable iff (RESET) // R05
    ##1 FRACTIONAL_MODE == ($past(order_q) != 2'h0))
    else $error("mode disagrees with order");
  // R07 gpio mirrors status
  a_gpio_live: assert property (@(posedge MCLK) disable iff (RESET) // R07
    LOCK_GPIO == lock_live_q)
    else $error("gpio and status lock differ");
  // R07 loss is recorded
  a_sticky_loss: assert property (@(posedge MCLK) disable iff (RESET) // R07
    $fell(lock_live_q) |-> lock_sticky_q)
    else $error("lock loss not recorded");
  // R19 sticky holds
  a_sticky_hold: assert property (@(posedge MCLK) disable iff (RESET) // R19
    (lock_sticky_q && !sticky_clr) |=> lock_sticky_q)
    else $error("sticky cleared without software");
  // R13 disabled means flat
  a_ssc_off: assert property (@(posedge MCLK) disable iff (RESET) // R13
    !ssc_en_q [*2] |-> SSC_OFFSET == 16'h0000 && !SSC_ACTIVE)
    else $error("spread present while disabled");
  // R13 down stays negative
  a_down_sign: assert property (@(posedge MCLK) disable iff (RESET) // R13
    (SSC_ACTIVE && !$past(ssc_type_q)) |-> (SSC_OFFSET == 16'h0000 || SSC_OFFSET[15]))
    else $error("down spread went positive");
  // R14 reserved codes idle
  a_ssc_bad_code: assert property (@(posedge MCLK) disable iff (RESET) // R14
    (ssc_sel_q > FPS_SSC_LAST_CODE) |=> !SSC_ACTIVE)
    else $error("reserved spread code active");

  c_lock_loss: cover property (@(posedge MCLK) disable iff (RESET) lock_lost);
  c_sticky_clear: cover property (@(posedge MCLK) disable iff (RESET) lock_sticky_q ##1 !lock_sticky_q);
  c_center_ssc: cover property (@(posedge MCLK) disable iff (RESET) SSC_ACTIVE && ssc_type_q && ramp == FPS_SSC_HALF);
  c_doubler: cover property (@(posedge MCLK) disable iff (RESET) PFD_DOUBLER_EN);
endmodule : fps_ctrl
`default_nettype wire

// ---- tb/fps_ctrl_test.sv ----
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// Self-checking bench for the synthesizer control block
module fps_ctrl_test;
  import fps_pkg::*;
  localparam int LIMIT = 40000;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [6:0] addr = 7'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic lock_in = 1'b0;
  logic [15:0] rdata;
  logic rvalid;
  logic lock_gpio, dbl, frac_mode, pfd_se, frac_ctrl, ssc_act, ssc_50, pll_run;
  logic [7:0] ref_div;
  logic [14:0] n_int;
  logic [23:0] num;
  logic [24:0] den;
  logic [1:0] order;
  logic [2:0] lock_win;
  logic [15:0] ssc_off;
  logic [15:0] o1, o2;
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;

  // =====================================================================
  // Clock and device under test
  always #5 mclk = ~mclk;

  fps_ctrl fps_ctrl_i (.MCLK(mclk), .RESET(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_s),
    .REG_RD(rd_s), .REG_RDATA(rdata), .REG_RVALID(rvalid), .LOCK_DETECT_IN(lock_in), .LOCK_GPIO(lock_gpio),
    .REFERENCE_DIVIDE_VALUE(ref_div), .PFD_DOUBLER_EN(dbl), .FEEDBACK_INTEGER_VALUE(n_int), .FRAC_NUM(num),
    .FRAC_DEN(den), .CASCADED_NOISE_SHAPER(order), .FRACTIONAL_MODE(frac_mode), .PFD_SINGLE_ENDED(pfd_se),
    .FRAC_PATH_CTRL(frac_ctrl), .LOCK_WINDOW(lock_win), .SSC_ACTIVE(ssc_act), .SSC_PFD_50M(ssc_50),
    .SSC_OFFSET(ssc_off), .PLL_RUN(pll_run));

  // =====================================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Write strobe for one cycle, then let mirrored outputs settle
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge mclk);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge mclk);
    wr_s = 1'b0;
    @(negedge mclk);
  endtask : wr

  // Read strobe for one cycle; answer is sampled one edge later
  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    @(negedge mclk);
    addr = a;
    rd_s = 1'b1;
    @(negedge mclk);
    rd_s = 1'b0;
    check(rvalid, 1);
    check(rdata, exp);
  endtask : rd

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // Hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_count++;
      tally_and_finish();
    end
  end

  // =====================================================================
  // Test sequence
  initial begin
    repeat (20) @(negedge mclk);
    check(ref_div, FPS_RST_REF_DIV);
    check(n_int, FPS_RST_FB_INT);
    check(den, FPS_DEN_FULL);
    check(pfd_se, FPS_RST_PFD_SE);
    check(pll_run, 0);
    rst = 1'b0;
    @(negedge mclk);
    check(pll_run, 1);
    $display("test reset done");

    // lockable setup: 25 MHz input, PFD 25 MHz, N 96 gives 2400 MHz
    wr(FPS_OFF_REF_DIV, 16'h0001);
    wr(FPS_OFF_FB_INT, 16'h0060);
    check({ref_div, n_int}, {8'h01, 15'h0060});
    // channel power lives outside this block; the feedback path is never gated here

    wr(FPS_OFF_REF_DIV, 16'h0000);
    check({dbl, ref_div}, 9'h100);
    wr(FPS_OFF_REF_DIV, 16'hffff);
    check({dbl, ref_div}, 9'h0ff);
    rd(FPS_OFF_REF_DIV, 16'h00ff);
    wr(FPS_OFF_FB_INT, 16'hffff);
    check(n_int, 15'h7fff);
    rd(FPS_OFF_FB_INT, 16'h7fff);
    wr(FPS_OFF_NUM_LO, 16'h1234);
    wr(FPS_OFF_NUM_HI, 16'hffab);
    check(num, 24'hab1234);
    rd(FPS_OFF_NUM_HI, 16'h00ab);
    wr(FPS_OFF_DEN_LO, 16'h0002);
    wr(FPS_OFF_DEN_HI, 16'h0001);
    check(den, 25'h0010002);
    wr(FPS_OFF_DEN_LO, 16'h0000);
    wr(FPS_OFF_DEN_HI, 16'h0000);
    check(den, FPS_DEN_FULL);
    $display("test dividers done");

    for (int i = 0; i < 4; i++) begin
      wr(FPS_OFF_MOD_ORDER, 16'(i));
      check({frac_mode, order}, {(i != 0), 2'(i)});
    end
    wr(FPS_OFF_DET_CFG, 16'h0400);
    check({pfd_se, frac_ctrl}, 2'b01);
    wr(FPS_OFF_LOCK_WIN, 16'h0700);
    check(lock_win, 3'h7);
    rd(FPS_OFF_LOCK_WIN, 16'h0700);
    rd(7'h10, 16'h0000);
    $display("test modes done");

    lock_in = 1'b1;
    @(negedge mclk);
    check(lock_gpio, 1);
    rd(FPS_OFF_LOCK_STATUS, 16'h0001);
    lock_in = 1'b0;
    @(negedge mclk);
    check(lock_gpio, 0);
    lock_in = 1'b1;
    @(negedge mclk);
    rd(FPS_OFF_LOCK_STATUS, 16'h0003);
    wr(FPS_OFF_LOCK_STATUS, 16'h0001);
    rd(FPS_OFF_LOCK_STATUS, 16'h0003);
    wr(FPS_OFF_LOCK_STATUS, 16'h0002);
    rd(FPS_OFF_LOCK_STATUS, 16'h0001);
    // loss and clear in one cycle, loss wins
    @(negedge mclk);
    addr = FPS_OFF_LOCK_STATUS;
    wdata = 16'h0002;
    wr_s = 1'b1;
    lock_in = 1'b0;
    @(negedge mclk);
    wr_s = 1'b0;
    lock_in = 1'b1;
    @(negedge mclk);
    rd(FPS_OFF_LOCK_STATUS, 16'h0003);
    $display("test lock done");

    // triangle slope for each preset code
    for (int c = 0; c < 4; c++) begin
      // PFD at 25 MHz for codes 0..1, doubled to 50 MHz for codes 2..3
      wr(FPS_OFF_REF_DIV, c[1] ? 16'h0000 : 16'h0001);
      wr(FPS_OFF_SSC_SEL, 16'((c[1] << 5) | (c << 1)));
      wr(FPS_OFF_SSC_EN, 16'h8000);
      repeat (50) @(negedge mclk);
      o1 = ssc_off;
      @(negedge mclk);
      o2 = ssc_off;
      check({ssc_act, ssc_50}, {1'b1, c[1]});
      check(16'(o2 - o1), c[0] ? 16'hfffe : 16'hffff);
      check(o1[15], !c[1]);
      repeat (1600) @(negedge mclk);
      o1 = ssc_off;
      @(negedge mclk);
      o2 = ssc_off;
      check(16'(o2 - o1), c[0] ? 16'h0002 : 16'h0001);
      // Ramp 1652 steps in has turned at the apex and fallen back to twice the half period less 1652
      check(o2, 16'((c[1] ? (FPS_SSC_MID << c[0]) : 0) - ((2 * FPS_SSC_HALF - 1652) << c[0])));
      wr(FPS_OFF_SSC_EN, 16'h0000);
      check({ssc_act, ssc_off}, 17'h0);
    end
    wr(FPS_OFF_SSC_SEL, 16'h0008);
    wr(FPS_OFF_SSC_EN, 16'h8000);
    repeat (20) @(negedge mclk);
    check({ssc_act, ssc_off}, 17'h0);
    $display("test spread done");
    tally_and_finish();
  end
endmodule : fps_ctrl_test
`default_nettype wire
